// ### src/ralc_pkg.sv
// Shared constants and types for the record level control
//
// What this block does
// - While active, continuously adjust record gain from the ADC output peak.
// - Channel select 00 off, 01 right, 10 left, 11 both channels.
// - Target code 0 is -28.5 dBFS, 1.5 dB per code, default 1011.
// - Hold code 0 is zero, 1 is 2.67 ms, doubling per code.
// - Hold delays only gain increase; gain falls at once above target.
// - Ramp-up time 24 ms doubling per code, capped from code 1010.
// - Ramp-down time 6 ms doubling per code, capped from code 1010.
// - Stereo uses the larger channel peak and drives both amplifiers alike.
// - Single-channel mode drives only that amplifier; other keeps register gain.
// - An unused ADC channel is ignored by the peak measurement.
// - Ceiling caps gain, 111 is +30 dB, 6 dB less per code.
// - Zero-cross wait is 2^14 to 2^17 bit clocks, default 11.
// - Above 87.5% full scale, lower gain at the fastest attack rate.
// - Gate engages when ADC level is below threshold plus gain plus boost.
// - Engaged gate freezes gain; gate type bit also mutes the ADC output.
// - Gate works only with level control, on the governed channels.
// - While level control governs a channel, register gain writes do nothing.
// - Level control always drives extended range, 0.75 dB steps from -17.25 dB.
package ralc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [6:0] ADDR_TIMING = 7'h60;
    localparam logic [6:0] ADDR_MODE = 7'h62;
    localparam logic [15:0] RST_TIMING = 16'hB032;
    localparam logic [15:0] RST_MODE = 16'h3E00;
    // Bits 8 and 6 of the mode register are reserved and read zero
    localparam logic [15:0] MODE_MASK = 16'hFEBF;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SYS_KHZ = 50000;
    localparam int BCLK_KHZ = 12288;
    localparam int HOLD_BASE_LOG2 = 14;
    localparam int ZCW_BASE_LOG2 = 14;
    localparam int DECAY_BASE_US = 24000;
    localparam int ATTACK_BASE_US = 6000;
    // Codes crossed by a ramp over 90% of the 64-code range
    localparam int RAMP_STEPS = 57;
    localparam int DECAY_TICKS = DECAY_BASE_US * BCLK_KHZ / 1000 / RAMP_STEPS;
    localparam int ATTACK_TICKS = ATTACK_BASE_US * BCLK_KHZ / 1000 / RAMP_STEPS;
    localparam logic [3:0] RAMP_CODE_MAX = 4'hA;

    // ************************************************************
    // Levels, in 0.75 dB units on a log scale where 120 is full scale
    // ************************************************************
    localparam logic [8:0] TGT_OFS = 9'h052;
    localparam logic [8:0] GATE_OFS = 9'h005;
    localparam logic [15:0] LIMIT_MAG = 16'h7000;
    localparam logic [5:0] GAIN_MAX = 6'h3F;
    localparam logic [5:0] GAIN_RST = 6'h17;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic [3:0] target;
        logic [3:0] hold;
        logic [3:0] rampup;
        logic [3:0] rampdown;
    } ralc_timing_t;

    typedef struct packed {
        logic [1:0] chan_sel;
        logic [2:0] ceiling;
        logic [1:0] zc_wait;
        logic rsv8;
        logic gate_en;
        logic rsv6;
        logic gate_type;
        logic [4:0] gate_th;
    } ralc_mode_t;

    typedef struct packed {
        logic [6:0] level;
        logic limit;
    } ralc_peak_t;

    typedef enum logic [2:0] {ST_OFF, ST_HOLD, ST_UP, ST_DOWN, ST_FREEZE} ralc_state_t;

endpackage

// ### src/ralc_peak_meter.sv
// Per-sample peak measurement of the governed ADC channels
`timescale 1ns/1ns
`default_nettype none
module ralc_peak_meter (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic sample_valid, // New ADC sample pair
    input wire logic [15:0] adc_l, // Left sample, signed
    input wire logic [15:0] adc_r, // Right sample, signed
    input wire logic use_l, // Left counts
    input wire logic use_r, // Right counts
    output ralc_pkg::ralc_peak_t peak, // Log level and limit flag
    output logic peak_valid // Peak updated
);
    import ralc_pkg::*;

    // Leading one gives 8 units per octave, next three bits refine it
    function automatic logic [6:0] log_level(input logic [15:0] m);
        logic [6:0] r;
        logic [15:0] sh;
        r = 7'h00;
        for (int i = 1; i < 16; i++) begin
            sh = 16'(m << (15 - i));
            if (m[i]) begin
                r = {4'(i), sh[14:12]};
            end
        end
        return r;
    endfunction

    wire logic [15:0] mag_l = adc_l[15] ? 16'(-adc_l) : adc_l;
    wire logic [15:0] mag_r = adc_r[15] ? 16'(-adc_r) : adc_r;
    wire logic [15:0] cut_l = use_l ? mag_l : 16'h0000;
    wire logic [15:0] cut_r = use_r ? mag_r : 16'h0000;
    wire logic [15:0] mag_max = (cut_l > cut_r) ? cut_l : cut_r;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            peak <= '0;
            peak_valid <= 1'b0;
        end else begin
            peak_valid <= sample_valid;
            if (sample_valid) begin
                peak.level <= log_level(mag_max);
                peak.limit <= mag_max > LIMIT_MAG;
            end
        end
    end
endmodule // ralc_peak_meter
`default_nettype wire

// ### src/ralc_step_timer.sv
// Interval timer that paces single gain steps on bit-clock ticks
`timescale 1ns/1ns
`default_nettype none
module ralc_step_timer #(
    parameter int W = 24
) (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic tick, // Bit-clock rate enable
    input wire logic run, // Ramp in progress
    input wire logic [W-1:0] interval, // Ticks per step
    output logic step // One-cycle step pulse
);
    if (W < 4) begin : g_chk
        $error("ralc_step_timer: W too small");
    end

    logic [W-1:0] count_r;
    wire logic last = count_r >= interval - W'(1);

    assign step = run && tick && last;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count_r <= '0;
        end else if (!run || step) begin
            count_r <= '0;
        end else if (tick) begin
            count_r <= count_r + W'(1);
        end
    end
endmodule // ralc_step_timer
`default_nettype wire

// ### src/ralc_top.sv
// Record-path automatic level control with limiter and noise gate
`timescale 1ns/1ns
`default_nettype none
module ralc_top #(
    parameter int BCLK_NUM = ralc_pkg::BCLK_KHZ,
    parameter int SYS_DEN = ralc_pkg::SYS_KHZ,
    parameter int HOLD_BASE = ralc_pkg::HOLD_BASE_LOG2,
    parameter int ZCW_BASE = ralc_pkg::ZCW_BASE_LOG2,
    parameter int DECAY_T = ralc_pkg::DECAY_TICKS,
    parameter int ATTACK_T = ralc_pkg::ATTACK_TICKS
) (
    input wire logic sys_clk, // System clock, 50 MHz
    input wire logic reset, // Async reset, active high
    input wire logic reg_wr, // Control register write strobe
    input wire logic [6:0] reg_addr, // Control register address
    input wire logic [15:0] reg_wdata, // Write data
    output logic [15:0] reg_rdata, // Read data, one cycle late
    input wire logic adc_valid, // ADC sample strobe
    input wire logic [15:0] adc_l, // Left ADC sample
    input wire logic [15:0] adc_r, // Right ADC sample
    input wire logic adc_on_l, // Left ADC in use
    input wire logic adc_on_r, // Right ADC in use
    input wire logic [5:0] reg_gain_l, // Left gain from gain register
    input wire logic [5:0] reg_gain_r, // Right gain from gain register
    input wire logic reg_ext_l, // Left range from gain register
    input wire logic reg_ext_r, // Right range from gain register
    input wire logic [6:0] boost_gain, // Mic boost in 0.75 dB units
    output logic [5:0] pga_gain_l, // Left amplifier gain code
    output logic [5:0] pga_gain_r, // Right amplifier gain code
    output logic pga_ext_l, // Left extended range
    output logic pga_ext_r, // Right extended range
    output logic mute_l, // Left ADC output mute
    output logic mute_r // Right ADC output mute
);
    import ralc_pkg::*;

    // Timeout limit is a 28-bit shift; base plus code 3 must stay below bit 28
    if (BCLK_NUM < 1 || BCLK_NUM > SYS_DEN || HOLD_BASE > 15 || ZCW_BASE > 24
            || DECAY_T < 1 || ATTACK_T < 1 || DECAY_T > 16383 || ATTACK_T > 16383) begin : g_chk
        $error("ralc_top: timing parameters out of range");
    end

    // ************************************************************
    // Bit-clock rate enable
    // ************************************************************
    // Fractional accumulator keeps the average tick rate exact
    logic [16:0] acc_r;
    wire logic [17:0] acc_sum = 18'(acc_r) + 18'(BCLK_NUM);
    wire logic tick = acc_sum >= 18'(SYS_DEN);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            acc_r <= '0;
        end else begin
            acc_r <= tick ? 17'(acc_sum - 18'(SYS_DEN)) : 17'(acc_sum);
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    ralc_timing_t tm_r;
    ralc_mode_t md_r;

    wire logic wr_tm = reg_wr && reg_addr == ADDR_TIMING;
    wire logic wr_md = reg_wr && reg_addr == ADDR_MODE;
    wire logic [15:0] rd_sel = (reg_addr == ADDR_TIMING) ? tm_r
        : (reg_addr == ADDR_MODE) ? (md_r & MODE_MASK) : 16'h0000;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tm_r <= RST_TIMING;
            md_r <= RST_MODE;
            reg_rdata <= 16'h0000;
        end else begin
            if (wr_tm) begin
                tm_r <= reg_wdata;
            end
            if (wr_md) begin
                md_r <= reg_wdata & MODE_MASK;
            end
            reg_rdata <= rd_sel;
        end
    end

    // ************************************************************
    // Mode decode
    // ************************************************************
    wire logic ctl_l = md_r.chan_sel[1];
    wire logic ctl_r = md_r.chan_sel[0];
    wire logic alc_on = ctl_l || ctl_r;
    wire logic [5:0] ceil_code = GAIN_MAX - {~md_r.ceiling, 3'b000};

    // ************************************************************
    // Peak measurement
    // ************************************************************
    ralc_peak_t pk;
    logic pv;

    ralc_peak_meter u_peak (
        .sys_clk(sys_clk),
        .reset(reset),
        .sample_valid(adc_valid),
        .adc_l(adc_l),
        .adc_r(adc_r),
        .use_l(adc_on_l && ctl_l),
        .use_r(adc_on_r && ctl_r),
        .peak(pk),
        .peak_valid(pv)
    );

    // ************************************************************
    // Level decisions
    // ************************************************************
    logic [5:0] alc_gain_r;
    logic [5:0] out_gain_r;
    ralc_state_t state_r;
    ralc_state_t state_nxt;
    logic fast_r;
    logic gate_on_r;

    wire logic above = 9'(pk.level) > TGT_OFS + 9'({tm_r.target, 1'b0});
    wire logic [8:0] gate_lhs = 9'(pk.level) + GATE_OFS;
    wire logic [8:0] gate_rhs = 9'({md_r.gate_th, 1'b0}) + 9'(out_gain_r) + 9'(boost_gain);
    wire logic gate_hit = md_r.gate_en && gate_lhs < gate_rhs;

    // Hold timer, counts bit-clock ticks while waiting to ramp up
    logic [30:0] hold_cnt_r;
    wire logic [30:0] hold_lim = 31'(1) << (HOLD_BASE + int'(tm_r.hold));
    wire logic hold_zero = tm_r.hold == 4'h0;
    wire logic hold_done = hold_cnt_r >= hold_lim;

    always_comb begin
        state_nxt = state_r;
        if (!alc_on) begin
            state_nxt = ST_OFF;
        end else if (pv) begin
            if (pk.limit || above) begin
                state_nxt = ST_DOWN;
            end else if (gate_hit) begin
                state_nxt = ST_FREEZE;
            end else begin
                unique case (state_r)
                    ST_HOLD: if (hold_done) state_nxt = ST_UP;
                    ST_UP: state_nxt = ST_UP;
                    default: state_nxt = hold_zero ? ST_UP : ST_HOLD;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_OFF;
            fast_r <= 1'b0;
            gate_on_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (!alc_on) begin
                fast_r <= 1'b0;
                gate_on_r <= 1'b0;
            end else if (pv) begin
                fast_r <= pk.limit;
                gate_on_r <= gate_hit && !pk.limit && !above;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hold_cnt_r <= '0;
        end else if (state_r != ST_HOLD) begin
            hold_cnt_r <= '0;
        end else if (tick && !hold_done) begin
            hold_cnt_r <= hold_cnt_r + 31'(1);
        end
    end

    // ************************************************************
    // Ramp pacing
    // ************************************************************
    wire logic [3:0] up_code = (tm_r.rampup > RAMP_CODE_MAX) ? RAMP_CODE_MAX : tm_r.rampup;
    wire logic [3:0] dn_sat = (tm_r.rampdown > RAMP_CODE_MAX) ? RAMP_CODE_MAX : tm_r.rampdown;
    wire logic [3:0] dn_code = fast_r ? 4'h0 : dn_sat;
    wire logic [23:0] up_ivl = 24'(DECAY_T) << up_code;
    wire logic [23:0] dn_ivl = 24'(ATTACK_T) << dn_code;
    wire logic ramping = state_r == ST_UP || state_r == ST_DOWN;
    wire logic run = ramping && state_nxt == state_r;
    logic step;

    ralc_step_timer #(.W(24)) u_step (
        .sys_clk(sys_clk),
        .reset(reset),
        .tick(tick),
        .run(run),
        .interval(state_r == ST_DOWN ? dn_ivl : up_ivl),
        .step(step)
    );

    // ************************************************************
    // Gain computation
    // ************************************************************
    logic [5:0] alc_gain_nxt;

    always_comb begin
        alc_gain_nxt = alc_gain_r;
        if (alc_gain_r > ceil_code) begin
            alc_gain_nxt = ceil_code;
        end else if (step && state_r == ST_DOWN && alc_gain_r != 6'h00) begin
            alc_gain_nxt = alc_gain_r - 6'h01;
        end else if (step && state_r == ST_UP && alc_gain_r < ceil_code) begin
            alc_gain_nxt = alc_gain_r + 6'h01;
        end
    end

    // ************************************************************
    // Zero-cross application
    // ************************************************************
    // New gain waits for a sign change to avoid zipper noise
    logic prev_sign_r;
    logic [27:0] zcw_cnt_r;
    wire logic zc_sign = ctl_l ? adc_l[15] : adc_r[15];
    wire logic zc_hit = adc_valid && zc_sign != prev_sign_r;
    wire logic pending = alc_gain_r != out_gain_r;
    wire logic [27:0] zcw_lim = 28'(1) << (ZCW_BASE + int'(md_r.zc_wait));
    wire logic zcw_out = zcw_cnt_r >= zcw_lim;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            alc_gain_r <= GAIN_RST;
            out_gain_r <= GAIN_RST;
            prev_sign_r <= 1'b0;
            zcw_cnt_r <= '0;
        end else begin
            alc_gain_r <= alc_gain_nxt;
            if (adc_valid) begin
                prev_sign_r <= zc_sign;
            end
            if (!pending || zc_hit || zcw_out) begin
                zcw_cnt_r <= '0;
            end else if (tick) begin
                zcw_cnt_r <= zcw_cnt_r + 28'(1);
            end
            if (pending && (zc_hit || zcw_out || !alc_on)) begin
                out_gain_r <= alc_gain_r;
            end
        end
    end

    // ************************************************************
    // Amplifier and mute outputs
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pga_gain_l <= 6'h00;
            pga_gain_r <= 6'h00;
            pga_ext_l <= 1'b0;
            pga_ext_r <= 1'b0;
            mute_l <= 1'b0;
            mute_r <= 1'b0;
        end else begin
            pga_gain_l <= ctl_l ? out_gain_r : reg_gain_l;
            pga_gain_r <= ctl_r ? out_gain_r : reg_gain_r;
            pga_ext_l <= ctl_l || reg_ext_l;
            pga_ext_r <= ctl_r || reg_ext_r;
            mute_l <= ctl_l && gate_on_r && md_r.gate_type;
            mute_r <= ctl_r && gate_on_r && md_r.gate_type;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_stereo;
        md_r.chan_sel == 2'b11 [*2];
    endsequence

    a_register_gain_kept: assert property (!ctl_l |=> pga_gain_l == $past(reg_gain_l))
        else $error("uncontrolled left gain not taken from register");
    a_extended_range: assert property (ctl_r |=> pga_ext_r)
        else $error("controlled channel not in extended range");
    a_ceiling_clamp: assert property (alc_gain_r > ceil_code |=> alc_gain_r == $past(ceil_code))
        else $error("gain not clamped to ceiling");
    a_limiter_fast: assert property (alc_on && pv && pk.limit |=> state_r == ST_DOWN && fast_r)
        else $error("limiter did not force fast ramp-down");
    a_down_no_hold: assert property (alc_on && pv && above |=> state_r == ST_DOWN)
        else $error("ramp-down delayed above target");
    a_gate_freeze: assert property (state_r == ST_FREEZE |=> alc_gain_r <= $past(alc_gain_r))
        else $error("gain rose while gate engaged");
    a_gate_mute: assert property (ctl_l && gate_on_r && md_r.gate_type |=> mute_l)
        else $error("gate did not mute controlled channel");
    a_stereo_match: assert property (s_stereo |-> pga_gain_l == pga_gain_r)
        else $error("stereo gains differ");
    a_single_step: assert property (alc_gain_r <= ceil_code && $stable(ceil_code)
            |=> alc_gain_r - $past(alc_gain_r) inside {6'h00, 6'h01, 6'h3F})
        else $error("gain moved more than one code");
    a_hold_wait: assert property (state_r == ST_HOLD ##1 state_r == ST_UP |-> $past(hold_done))
        else $error("ramp-up began before hold expired");

endmodule // ralc_top
`default_nettype wire

// ### bench/ralc_adc_model.sv
// Behavioural record amplifier and ADC that feed the level control
`timescale 1ns/1ns
`default_nettype none
module ralc_adc_model (
    input wire logic sys_clk, // System clock
    input wire logic reset, // Async reset, active high
    input wire logic [15:0] amp_l, // Left tone amplitude
    input wire logic [15:0] amp_r, // Right tone amplitude
    output logic adc_valid, // Sample strobe
    output logic [15:0] adc_l, // Left sample
    output logic [15:0] adc_r // Right sample
);
    logic [3:0] cnt_r;
    logic sign_r;
    logic [15:0] val_l;
    logic [15:0] val_r;
    // Open loop: amplitude does not follow the gain, so ramps run to their ends
    assign val_l = sign_r ? -amp_l : amp_l;
    assign val_r = sign_r ? -amp_r : amp_r;
    // Junk between strobes, so a stale sample can never pass for a new one
    assign adc_l = adc_valid ? val_l : ~val_l;
    assign adc_r = adc_valid ? val_r : ~val_r;
    always @(negedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 4'h0;
            sign_r <= 1'b0;
            adc_valid <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            adc_valid <= (cnt_r == 4'hF);
            if (cnt_r == 4'hF) sign_r <= ~sign_r;
        end
    end
endmodule // ralc_adc_model
`default_nettype wire

// ### bench/record_auto_level_control_test.sv
// Self-checking bench for the record level control
`timescale 1ns/1ns
`default_nettype none
module record_auto_level_control_test;
    import ralc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic adc_valid;
    logic [15:0] adc_l;
    logic [15:0] adc_r;
    logic adc_on_l = 1'b1;
    logic adc_on_r = 1'b1;
    logic [5:0] reg_gain_l = 6'h00;
    logic [5:0] reg_gain_r = 6'h00;
    logic reg_ext_l = 1'b0;
    logic reg_ext_r = 1'b0;
    logic [6:0] boost_gain = 7'h00;
    logic [15:0] amp_l = 16'h0400;
    logic [15:0] amp_r = 16'h0400;
    logic [5:0] pga_gain_l;
    logic [5:0] pga_gain_r;
    logic pga_ext_l;
    logic pga_ext_r;
    logic mute_l;
    logic mute_r;
    int miscompares = 0;
    int checks = 0;

    // ************************************************************
    // Design, far side and clock
    // ************************************************************
    ralc_top #(.BCLK_NUM(50000), .HOLD_BASE(2), .ZCW_BASE(2),
        .DECAY_T(4), .ATTACK_T(2)) DUT (.sys_clk(sys_clk), .reset(reset),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_valid(adc_valid), .adc_l(adc_l), .adc_r(adc_r), .adc_on_l(adc_on_l),
        .adc_on_r(adc_on_r), .reg_gain_l(reg_gain_l), .reg_gain_r(reg_gain_r),
        .reg_ext_l(reg_ext_l), .reg_ext_r(reg_ext_r), .boost_gain(boost_gain),
        .pga_gain_l(pga_gain_l), .pga_gain_r(pga_gain_r), .pga_ext_l(pga_ext_l),
        .pga_ext_r(pga_ext_r), .mute_l(mute_l), .mute_r(mute_r));
    ralc_adc_model adc (.sys_clk(sys_clk), .reset(reset), .amp_l(amp_l), .amp_r(amp_r),
        .adc_valid(adc_valid), .adc_l(adc_l), .adc_r(adc_r));
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [5:0] ceil_code(input logic [2:0] c);
        // -12 dB is code 7, and each ceiling step of 6 dB is 8 codes
        return 6'(7 + 8 * c);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        // Idle cycle so a following write never re-raises the strobe at once
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        reg_addr = a;
        @(negedge sys_clk);
        chk(reg_rdata, exp);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk_gain(input logic [5:0] e);
        chk({pga_ext_l, pga_ext_r, pga_gain_l, pga_gain_r, 2'b00}, {2'b11, e, e, 2'b00});
    endtask
    task automatic final_report;
        if (miscompares == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        void'($urandom(32'h074d_5287));
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        rd(ADDR_TIMING, 16'hB032);
        rd(ADDR_MODE, 16'h3E00);
        rd(7'h10, 16'h0000);
        wr(ADDR_MODE, 16'hFFFF);
        rd(ADDR_MODE, 16'hFFFF & MODE_MASK);
        wr(ADDR_MODE, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            reg_gain_l = 6'($urandom);
            reg_gain_r = 6'($urandom);
            reg_ext_l = 1'($urandom);
            reg_ext_r = 1'($urandom);
            waitc(2);
            chk({pga_ext_l, pga_ext_r, pga_gain_l, pga_gain_r, 2'b00},
                {reg_ext_l, reg_ext_r, reg_gain_l, reg_gain_r, 2'b00});
        end
        // Loud tone with the longest hold: gain must still fall at once
        wr(ADDR_TIMING, 16'hBF00);
        wr(ADDR_MODE, 16'hF800);
        amp_l = 16'h7800;
        amp_r = 16'h7800;
        for (int i = 0; i < 100; i++) begin
            waitc(15);
            reg_gain_l = 6'($urandom);
            reg_gain_r = 6'($urandom);
        end
        chk_gain(6'h00);
        amp_l = 16'h0400;
        amp_r = 16'h0400;
        waitc(2000);
        chk_gain(6'h00);
        wr(ADDR_TIMING, 16'hB000);
        wr(ADDR_MODE, 16'hD800);
        waitc(3000);
        chk_gain(ceil_code(3'h3));
        // Loud tone on an unused left channel must not pull the gain down
        adc_on_l = 1'b0;
        amp_l = 16'h7800;
        waitc(1000);
        chk_gain(ceil_code(3'h3));
        adc_on_l = 1'b1;
        amp_l = 16'h0400;
        wr(ADDR_MODE, 16'h5800);
        for (int i = 0; i < 4; i++) begin
            reg_gain_l = 6'($urandom);
            reg_ext_l = 1'($urandom);
            waitc(40);
            chk({pga_ext_l, pga_ext_r, pga_gain_l, pga_gain_r, 2'b00},
                {reg_ext_l, 1'b1, reg_gain_l, ceil_code(3'h3), 2'b00});
        end
        // Left only; right ADC use is toggled and must not matter
        wr(ADDR_MODE, 16'h9800);
        for (int i = 0; i < 4; i++) begin
            reg_gain_r = 6'($urandom);
            reg_ext_r = 1'($urandom);
            adc_on_r = 1'($urandom);
            waitc(40);
            chk({pga_ext_l, pga_ext_r, pga_gain_l, pga_gain_r, 2'b00},
                {1'b1, reg_ext_r, ceil_code(3'h3), reg_gain_r, 2'b00});
        end
        adc_on_r = 1'b1;
        wr(ADDR_MODE, 16'hD8BF);
        amp_l = 16'h0010;
        amp_r = 16'h0010;
        boost_gain = 7'h14;
        waitc(300);
        chk({14'h0000, mute_l, mute_r}, 16'h0003);
        chk_gain(ceil_code(3'h3));
        // Hold-only gate type: gain stays frozen, no mute
        wr(ADDR_MODE, 16'hD89F);
        waitc(50);
        chk({14'h0000, mute_l, mute_r}, 16'h0000);
        chk_gain(ceil_code(3'h3));
        wr(ADDR_MODE, 16'h00BF);
        waitc(50);
        chk({14'h0000, mute_l, mute_r}, 16'h0000);
        final_report();
    end
endmodule // record_auto_level_control_test
`default_nettype wire
